/* File: hw/channel_level_trigger_detector.sv */
`timescale 1ns/100ps
module channel_level_trigger_detector (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic signed [15:0] SAMPLE_DATA,
    input wire logic SAMPLE_VALID,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic TRIG_OUT,
    output logic QUAL_OUT
);
    cmp_if cmp_p ();
    cmp_if cmp_s ();
    bus_if bus ();

    function automatic logic reg_sel(input logic [4:0] addr, input logic [4:0] off);
        return addr[4:2] == off[4:2];
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // configuration registers
    trig_pkg::mode_type mode_reg, mode_next;
    logic dir_reg, dir_next;
    logic signed [15:0] plevel_reg, plevel_next, slevel_reg, slevel_next;
    logic [15:0] hyst_reg, hyst_next;
    logic cnt_clr;
    logic [31:0] merged;

    // detector state
    trig_pkg::mode_type seen_mode_reg, seen_mode_next;
    logic seen_dir_reg, seen_dir_next;
    logic win_armed_reg, win_armed_next;
    logic dwp_armed_reg, dwp_armed_next;
    logic dws_armed_reg, dws_armed_next;
    logic seq_armed_reg, seq_armed_next;
    logic trig_reg, trig_next, qual_reg, qual_next;
    logic [15:0] trig_cnt_reg, trig_cnt_next, qual_cnt_reg, qual_cnt_next;
    logic cfg_chg, pf, pr, sf, sr, s_any, fire, qfire;

    avmm_slave u_bus (
        .clk(MCLK),
        .rst_n(RSTN),
        .address(AVS_ADDRESS),
        .read(AVS_READ),
        .write(AVS_WRITE),
        .byteenable(AVS_BYTEENABLE),
        .writedata(AVS_WRITEDATA),
        .readdata(AVS_READDATA),
        .waitrequest(AVS_WAITREQUEST),
        .bus(bus.slv)
    );

    level_comparator u_cmp_p (
        .clk(MCLK),
        .rst_n(RSTN),
        .port(cmp_p.cmp)
    );

    level_comparator u_cmp_s (
        .clk(MCLK),
        .rst_n(RSTN),
        .port(cmp_s.cmp)
    );

    // register file: write side and read mux
    always_comb begin
        mode_next = mode_reg;
        dir_next = dir_reg;
        plevel_next = plevel_reg;
        slevel_next = slevel_reg;
        hyst_next = hyst_reg;
        cnt_clr = 1'b0;
        merged = 32'h0000_0000;
        if (bus.wr_stb && reg_sel(bus.addr, trig_pkg::OFF_CTRL)) begin
            merged = {27'h000_0000, dir_reg, 1'b0, mode_reg};
            merged = merge_bytes(merged, bus.wdata, bus.be);
            mode_next = trig_pkg::mode_type'(merged[trig_pkg::CTRL_MODE_LSB +: trig_pkg::CTRL_MODE_W]); // [RQ22]
            dir_next = merged[trig_pkg::CTRL_DIR_BIT];
        end
        if (bus.wr_stb && reg_sel(bus.addr, trig_pkg::OFF_PLEVEL)) begin
            merged = merge_bytes({16'h0000, plevel_reg}, bus.wdata, bus.be);
            plevel_next = merged[15:0]; // [RQ7]
        end
        if (bus.wr_stb && reg_sel(bus.addr, trig_pkg::OFF_SLEVEL)) begin
            merged = merge_bytes({16'h0000, slevel_reg}, bus.wdata, bus.be);
            slevel_next = merged[15:0]; // [RQ7]
        end
        if (bus.wr_stb && reg_sel(bus.addr, trig_pkg::OFF_HYST)) begin
            merged = merge_bytes({16'h0000, hyst_reg}, bus.wdata, bus.be);
            hyst_next = merged[15:0];
        end
        // any write to the counter word clears both counters, whatever the byte enables
        if (bus.wr_stb && reg_sel(bus.addr, trig_pkg::OFF_COUNT)) begin
            cnt_clr = 1'b1;
        end
        bus.rdata = 32'h0000_0000;
        if (reg_sel(bus.addr, trig_pkg::OFF_CTRL)) begin
            bus.rdata[trig_pkg::CTRL_MODE_LSB +: trig_pkg::CTRL_MODE_W] = mode_reg;
            bus.rdata[trig_pkg::CTRL_DIR_BIT] = dir_reg;
        end else if (reg_sel(bus.addr, trig_pkg::OFF_PLEVEL)) begin
            bus.rdata[15:0] = plevel_reg;
        end else if (reg_sel(bus.addr, trig_pkg::OFF_SLEVEL)) begin
            bus.rdata[15:0] = slevel_reg;
        end else if (reg_sel(bus.addr, trig_pkg::OFF_HYST)) begin
            bus.rdata[15:0] = hyst_reg;
        end else if (reg_sel(bus.addr, trig_pkg::OFF_STATUS)) begin
            bus.rdata[trig_pkg::ST_WIN_BIT] = win_armed_reg;
            bus.rdata[trig_pkg::ST_DWP_BIT] = dwp_armed_reg;
            bus.rdata[trig_pkg::ST_DWS_BIT] = dws_armed_reg;
            bus.rdata[trig_pkg::ST_SEQ_BIT] = seq_armed_reg;
        end else if (reg_sel(bus.addr, trig_pkg::OFF_COUNT)) begin
            bus.rdata[trig_pkg::CNT_TRIG_LSB +: trig_pkg::CNT_W] = trig_cnt_reg;
            bus.rdata[trig_pkg::CNT_QUAL_LSB +: trig_pkg::CNT_W] = qual_cnt_reg;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_reg <= trig_pkg::MODE_OFF;
            dir_reg <= trig_pkg::RESET_DIR;
            plevel_reg <= trig_pkg::RESET_LEVEL;
            slevel_reg <= trig_pkg::RESET_LEVEL;
            hyst_reg <= trig_pkg::RESET_HYST;
        end else begin
            mode_reg <= mode_next;
            dir_reg <= dir_next;
            plevel_reg <= plevel_next;
            slevel_reg <= slevel_next;
            hyst_reg <= hyst_next;
        end
    end

    // comparator wiring; a mode or direction change restarts both comparators unarmed
    always_comb begin
        cfg_chg = (mode_reg != seen_mode_reg) || (dir_reg != seen_dir_reg);
        cmp_p.sample = SAMPLE_DATA;
        cmp_p.valid = SAMPLE_VALID;
        cmp_p.level = plevel_reg;
        cmp_p.hyst = hyst_reg; // [RQ6]
        cmp_p.dir = dir_reg; // [RQ1]
        cmp_p.clear = cfg_chg || (mode_reg == trig_pkg::MODE_OFF); // [RQ23]
        cmp_s.sample = SAMPLE_DATA;
        cmp_s.valid = SAMPLE_VALID;
        cmp_s.level = slevel_reg;
        cmp_s.hyst = hyst_reg; // [RQ6]
        cmp_s.dir = ~dir_reg; // [RQ5]
        // secondary stays cleared until the primary has been crossed in sequential mode
        cmp_s.clear = cmp_p.clear || ((mode_reg == trig_pkg::MODE_SEQ) && !seq_armed_reg); // [RQ14]
    end

    // mode logic
    always_comb begin
        pf = cmp_p.hit_fwd & ~cfg_chg;
        pr = cmp_p.hit_rev & ~cfg_chg;
        sf = cmp_s.hit_fwd & ~cfg_chg;
        sr = cmp_s.hit_rev & ~cfg_chg;
        s_any = sf | sr;
        fire = 1'b0;
        qfire = 1'b0;
        win_armed_next = win_armed_reg;
        dwp_armed_next = dwp_armed_reg;
        dws_armed_next = dws_armed_reg;
        seq_armed_next = seq_armed_reg;
        seen_mode_next = mode_reg;
        seen_dir_next = dir_reg;
        unique case (mode_reg)
            trig_pkg::MODE_OFF: begin
                fire = 1'b0; // [RQ22]
            end
            trig_pkg::MODE_BASIC: begin
                fire = pf; // [RQ1]
            end
            trig_pkg::MODE_DUAL: begin
                // swapping the levels turns leave-the-range into re-enter-the-range
                fire = pf | sf; // [RQ3] [RQ4]
            end
            trig_pkg::MODE_WINDOW: begin
                fire = win_armed_reg & pf & ~s_any; // [RQ8] [RQ9]
                if (s_any || fire) begin
                    win_armed_next = 1'b0; // [RQ9] [RQ23]
                end else if (pr) begin
                    win_armed_next = 1'b1; // [RQ8]
                end
            end
            trig_pkg::MODE_DWINDOW: begin
                fire = (dwp_armed_reg & pf) | (dws_armed_reg & sf); // [RQ10] [RQ13]
                if (sf || (dwp_armed_reg && pf)) begin
                    dwp_armed_next = 1'b0; // [RQ12]
                end else if (pr) begin
                    dwp_armed_next = 1'b1; // [RQ11]
                end
                if (pf || (dws_armed_reg && sf)) begin
                    dws_armed_next = 1'b0; // [RQ12]
                end else if (sr) begin
                    dws_armed_next = 1'b1; // [RQ11]
                end
            end
            trig_pkg::MODE_SEQ: begin
                // no level ordering assumed: each comparator crosses on its own level
                fire = seq_armed_reg & sf; // [RQ14] [RQ15]
                if (fire) begin
                    seq_armed_next = 1'b0;
                end else if (pf) begin
                    seq_armed_next = 1'b1; // [RQ14]
                end
            end
            trig_pkg::MODE_QUAL1: begin
                qfire = pf; // [RQ16] [RQ17]
            end
            trig_pkg::MODE_QUAL2: begin
                qfire = pf | sf; // [RQ16] [RQ17]
            end
        endcase
        if (cfg_chg) begin
            win_armed_next = 1'b0; // [RQ23]
            dwp_armed_next = 1'b0;
            dws_armed_next = 1'b0;
            seq_armed_next = 1'b0;
        end
        trig_next = fire; // [RQ24]
        qual_next = qfire; // [RQ24]
        // an event in the clearing cycle still counts
        trig_cnt_next = cnt_clr ? trig_pkg::RESET_CNT : trig_cnt_reg;
        qual_cnt_next = cnt_clr ? trig_pkg::RESET_CNT : qual_cnt_reg;
        if (fire) begin
            trig_cnt_next = trig_cnt_next + 16'h0001;
        end
        if (qfire) begin
            qual_cnt_next = qual_cnt_next + 16'h0001;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            seen_mode_reg <= trig_pkg::MODE_OFF;
            seen_dir_reg <= trig_pkg::RESET_DIR;
            win_armed_reg <= 1'b0;
            dwp_armed_reg <= 1'b0;
            dws_armed_reg <= 1'b0;
            seq_armed_reg <= 1'b0;
            trig_reg <= 1'b0;
            qual_reg <= 1'b0;
            trig_cnt_reg <= trig_pkg::RESET_CNT;
            qual_cnt_reg <= trig_pkg::RESET_CNT;
        end else begin
            seen_mode_reg <= seen_mode_next;
            seen_dir_reg <= seen_dir_next;
            win_armed_reg <= win_armed_next;
            dwp_armed_reg <= dwp_armed_next;
            dws_armed_reg <= dws_armed_next;
            seq_armed_reg <= seq_armed_next;
            trig_reg <= trig_next;
            qual_reg <= qual_next;
            trig_cnt_reg <= trig_cnt_next;
            qual_cnt_reg <= qual_cnt_next;
        end
    end

    assign TRIG_OUT = trig_reg;
    assign QUAL_OUT = qual_reg;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);

    a_off_silent: assert property ( // [RQ22]
        mode_reg == trig_pkg::MODE_OFF |=> !trig_reg && !qual_reg)
        else $error("output while detector is off");

    a_basic_fires: assert property ( // [RQ1]
        (mode_reg == trig_pkg::MODE_BASIC) && cmp_p.hit_fwd && !cfg_chg
        |=> trig_reg ##1 !trig_reg)
        else $error("basic crossing did not give a one-cycle trigger");

    a_equal_level: assert property ( // [RQ18]
        (mode_reg == trig_pkg::MODE_BASIC) && SAMPLE_VALID && (SAMPLE_DATA == plevel_reg)
        |=> !trig_reg)
        else $error("sample equal to level triggered");

    a_strictly_beyond: assert property ( // [RQ2]
        trig_reg && $past(mode_reg) == trig_pkg::MODE_BASIC && $past(dir_reg)
        |-> $past(SAMPLE_VALID) && ($past(SAMPLE_DATA) > $past(plevel_reg)))
        else $error("positive trigger without a sample above the level");

    a_dual_either: assert property ( // [RQ3]
        (mode_reg == trig_pkg::MODE_DUAL) && !cfg_chg && (cmp_p.hit_fwd || cmp_s.hit_fwd)
        |=> trig_reg)
        else $error("dual crossing missed");

    a_sec_opposite: assert property ( // [RQ5]
        cmp_s.dir != cmp_p.dir && cmp_s.hyst == cmp_p.hyst)
        else $error("secondary direction or hysteresis wrong");

    a_win_unarmed: assert property ( // [RQ8]
        (mode_reg == trig_pkg::MODE_WINDOW) && !win_armed_reg |=> !trig_reg)
        else $error("window trigger while unarmed");

    a_win_disarm: assert property ( // [RQ9]
        (mode_reg == trig_pkg::MODE_WINDOW) && !cfg_chg && win_armed_reg && s_any
        |=> !win_armed_reg && !trig_reg)
        else $error("window disarm crossing ignored");

    a_dwin_trigger: assert property ( // [RQ13]
        (mode_reg == trig_pkg::MODE_DWINDOW) && !cfg_chg && dwp_armed_reg && cmp_p.hit_fwd
        |=> trig_reg && !dwp_armed_reg)
        else $error("armed dual-window crossing did not trigger");

    a_dwin_cross_disarm: assert property ( // [RQ12]
        (mode_reg == trig_pkg::MODE_DWINDOW) && !cfg_chg && cmp_p.hit_fwd && !cmp_s.hit_rev
        |=> !dws_armed_reg)
        else $error("other level stayed armed");

    a_seq_needs_arm: assert property ( // [RQ14]
        (mode_reg == trig_pkg::MODE_SEQ) && !seq_armed_reg |=> !trig_reg)
        else $error("sequential trigger before primary crossing");

    a_qual_route: assert property ( // [RQ16]
        (mode_reg == trig_pkg::MODE_QUAL1 || mode_reg == trig_pkg::MODE_QUAL2) && !cfg_chg && cmp_p.hit_fwd
        |=> qual_reg && !trig_reg)
        else $error("qualifier crossing not routed to qualifier line");

    a_cfg_clears: assert property ( // [RQ23]
        cfg_chg |=> !win_armed_reg && !dwp_armed_reg && !dws_armed_reg && !seq_armed_reg)
        else $error("arm state survived a mode change");

    a_bus_answer: assert property (
        AVS_WAITREQUEST && (AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer not in one cycle");

    c_basic_trig: cover property (mode_reg == trig_pkg::MODE_BASIC && trig_reg);
    c_window_trig: cover property (mode_reg == trig_pkg::MODE_WINDOW && trig_reg);
    c_dwin_trig: cover property (mode_reg == trig_pkg::MODE_DWINDOW && trig_reg);
    c_seq_trig: cover property (mode_reg == trig_pkg::MODE_SEQ && trig_reg);
    c_qual: cover property (qual_reg);
endmodule // channel_level_trigger_detector

/* File: hw/trig_pkg.sv */
// Function
// RQ1 - basic mode uses primary comparator; level and crossing direction are programmable
// RQ2 - trigger only when the signal passes through the level, not merely beyond it
// RQ3 - dual mode runs both comparators; trigger on leaving the range either way
// RQ4 - dual mode with inverted directions triggers on re-entering the range
// RQ5 - secondary direction is always the opposite of the primary direction
// RQ6 - one hysteresis amount serves both comparators
// RQ7 - each level takes any input value, independent of the other
// RQ8 - window mode arms on opposite crossing of primary; unarmed crossings never trigger
// RQ9 - window mode triggers on armed primary crossing; secondary crossing disarms
// RQ10 - dual-window treats both levels alike as arm, trigger and disarm levels
// RQ11 - dual-window arms a level on its opposite-direction crossing
// RQ12 - dual-window set-direction crossing of one level disarms the other
// RQ13 - dual-window set-direction crossing of an armed level triggers
// RQ14 - sequential mode enables secondary only after primary crossing; secondary triggers
// RQ15 - sequential mode works with primary below secondary; no ordering constraint
// RQ16 - qualifier modes drive the qualifier line instead of the trigger
// RQ17 - single-level qualifier acts as basic, two-level qualifier acts as dual
// RQ18 - trigger on first sample strictly beyond level; equal sample never triggers
// RQ19 - signal already beyond level at start gives no trigger until a crossing
// RQ20 - hysteresis is a second threshold that must be passed to arm the comparator
// RQ21 - recorder logic ORs all channel triggers together
// RQ22 - mode select covers off and seven modes; off gives no output
// RQ23 - window: primary arms and triggers, secondary disarms; arm states clear on reset or change
// RQ24 - output is a one-sample pulse registered the cycle after the sample
package trig_pkg;
    localparam int SAMPLE_W = 16;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int CNT_W = 16;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_PLEVEL = 5'h04;
    localparam logic [4:0] OFF_SLEVEL = 5'h08;
    localparam logic [4:0] OFF_HYST = 5'h0C;
    localparam logic [4:0] OFF_STATUS = 5'h10;
    localparam logic [4:0] OFF_COUNT = 5'h14;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W = 3;
    localparam int CTRL_DIR_BIT = 4;
    localparam int ST_WIN_BIT = 0;
    localparam int ST_DWP_BIT = 1;
    localparam int ST_DWS_BIT = 2;
    localparam int ST_SEQ_BIT = 3;
    localparam int CNT_TRIG_LSB = 0;
    localparam int CNT_QUAL_LSB = 16;
    localparam logic RESET_DIR = 1'b1;
    localparam logic [15:0] RESET_LEVEL = 16'h0000;
    localparam logic [15:0] RESET_HYST = 16'h0000;
    localparam logic [15:0] RESET_CNT = 16'h0000;
    typedef enum logic [2:0] {
        MODE_OFF, MODE_BASIC, MODE_DUAL, MODE_WINDOW,
        MODE_DWINDOW, MODE_SEQ, MODE_QUAL1, MODE_QUAL2
    } mode_type;
endpackage

/* File: hw/trig_if.sv */
`timescale 1ns/100ps
interface cmp_if;
    logic signed [15:0] sample;
    logic signed [15:0] level;
    logic [15:0] hyst;
    logic valid;
    logic dir;
    logic clear;
    logic hit_fwd;
    logic hit_rev;
    modport ctl (output sample, level, hyst, valid, dir, clear, input hit_fwd, hit_rev);
    modport cmp (input sample, level, hyst, valid, dir, clear, output hit_fwd, hit_rev);
endinterface // cmp_if

interface bus_if;
    logic [4:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] be;
    logic wr_stb;
    modport slv (output addr, wdata, be, wr_stb, input rdata);
    modport regs (input addr, wdata, be, wr_stb, output rdata);
endinterface // bus_if

/* File: hw/level_comparator.sv */
`timescale 1ns/100ps
module level_comparator (
    input wire logic clk,
    input wire logic rst_n,
    cmp_if.cmp port
);
    logic up_armed_reg, up_armed_next, down_armed_reg, down_armed_next;
    logic signed [17:0] smp, lvl, lo, hi;
    logic above, below, up_hit, down_hit;

    always_comb begin
        smp = {{2{port.sample[15]}}, port.sample};
        lvl = {{2{port.level[15]}}, port.level};
        lo = lvl - $signed({2'b00, port.hyst});
        hi = lvl + $signed({2'b00, port.hyst});
        above = smp > lvl; // [RQ18]
        below = smp < lvl; // [RQ18]
        up_hit = port.valid & up_armed_reg & above; // [RQ2]
        down_hit = port.valid & down_armed_reg & below; // [RQ2]
        up_armed_next = up_armed_reg;
        down_armed_next = down_armed_reg;
        // arming needs the far side of the hysteresis band, so noise at the level cannot re-fire
        if (port.clear) begin
            up_armed_next = 1'b0; // [RQ19]
            down_armed_next = 1'b0; // [RQ19]
        end else if (port.valid) begin
            if (smp < lo) begin
                up_armed_next = 1'b1; // [RQ20]
            end else if (above) begin
                up_armed_next = 1'b0;
            end
            if (smp > hi) begin
                down_armed_next = 1'b1; // [RQ20]
            end else if (below) begin
                down_armed_next = 1'b0;
            end
        end
        port.hit_fwd = port.dir ? up_hit : down_hit; // [RQ1]
        port.hit_rev = port.dir ? down_hit : up_hit;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_armed_reg <= 1'b0;
            down_armed_reg <= 1'b0;
        end else begin
            up_armed_reg <= up_armed_next;
            down_armed_reg <= down_armed_next;
        end
    end
endmodule // level_comparator

/* File: hw/avmm_slave.sv */
`timescale 1ns/100ps
module avmm_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    bus_if.slv bus
);
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;

    // fixed two-cycle access: request seen with wait high, answered one cycle later
    always_comb begin
        wait_next = wait_reg;
        rdata_next = rdata_reg;
        if (wait_reg && (read || write)) begin
            wait_next = 1'b0;
        end else if (!wait_reg) begin
            wait_next = 1'b1;
        end
        if (wait_reg && read) begin
            rdata_next = bus.rdata;
        end
        bus.addr = address;
        bus.wdata = writedata;
        bus.be = byteenable;
        bus.wr_stb = write & ~wait_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;
endmodule // avmm_slave

/* File: verif/rec_trig_model.sv */
`timescale 1ns/100ps
module rec_trig_model (
    input wire logic [1:0] chan_trig,
    output logic rec_trig
);
    // any single channel fires the whole recorder
    assign rec_trig = |chan_trig;
endmodule // rec_trig_model

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic mclk = 0;
    logic rstn = 0;
    logic valid = 0;
    logic rd = 0;
    logic wr = 0;
    logic signed [15:0] data = 16'h0000;
    logic [4:0] addr = 5'h00;
    logic [3:0] be = 4'hf;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic wreq, trig, qual, rec_trig;
    int bad_count = 0;
    int samples_checked = 0;
    int pu, pd, su, sd, wa, dp, ds, sq, pl, sl, hy, tc, qc, md;
    logic [31:0] rv;
    bit dr, et, eq;
    always #4 mclk = ~mclk;
    channel_level_trigger_detector dut_u (.MCLK(mclk), .RSTN(rstn), .SAMPLE_DATA(data), .SAMPLE_VALID(valid),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .TRIG_OUT(trig), .QUAL_OUT(qual));
    // second channel held quiet so the recorder line mirrors this channel
    rec_trig_model partner_u (.chan_trig({trig, 1'b0}), .rec_trig(rec_trig));
    task automatic stop_test();
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input bit w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b,
        output logic [31:0] q);
        int n;
        n = 0;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= b;
        do begin
            @(posedge mclk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        // read data stands at the edge that sees waitrequest low and holds until the next read
        q = rdata;
        rd <= 0;
        wr <= 0;
        if (n >= 50) begin
            bad_count++;
            stop_test();
        end
        @(posedge mclk);
    endtask
    task automatic cmp(inout int au, inout int ad, input int x, input int lv, input bit rise, output bit hf,
        output bit hr);
        bit hu, hd;
        // a hit needs a prior arming sample beyond the hysteresis band
        hu = au && x > lv;
        hd = ad && x < lv;
        if (x < lv - hy)
            au = 1;
        else if (x > lv)
            au = 0;
        if (x > lv + hy)
            ad = 1;
        else if (x < lv)
            ad = 0;
        hf = rise ? hu : hd;
        hr = rise ? hd : hu;
    endtask
    task automatic step(input int x, input bit v);
        bit pf, pr, sf, sr, so;
        data <= 16'(x);
        valid <= v;
        @(posedge mclk);
        chk({30'h0000_0000, rec_trig, qual}, {30'h0000_0000, et, eq});
        et = 0;
        eq = 0;
        so = sq;
        if (v) begin
            cmp(pu, pd, x, pl, dr, pf, pr);
            cmp(su, sd, x, sl, !dr, sf, sr);
            et = (md == 1 && pf) || (md == 2 && (pf || sf));
            eq = (md == 6 && pf) || (md == 7 && (pf || sf));
            if (md == 3) begin
                et = wa && pf && !(sf || sr);
                wa = (sf || sr || et) ? 0 : (pr ? 1 : wa);
            end
            if (md == 4) begin
                et = (dp && pf) || (ds && sf);
                dp = (sf || (dp && pf)) ? 0 : (pr ? 1 : dp);
                ds = (pf || (ds && sf)) ? 0 : (sr ? 1 : ds);
            end
            if (md == 5) begin
                et = sq && sf;
                sq = et ? 0 : (pf ? 1 : sq);
            end
            tc += et;
            qc += eq;
        end
        // secondary sits cleared in sequential mode until the primary has been crossed
        if (md == 5 && !so) begin
            su = 0;
            sd = 0;
        end
    endtask
    initial begin
        void'($urandom(72493));
        repeat (8) @(posedge mclk);
        rstn <= 1;
        @(posedge mclk);
        bus(0, 5'h00, 32'h0000_0000, 4'hf, rv);
        chk(rv, 32'h0000_0010);
        bus(1, 5'h04, 32'h1234_5678, 4'h1, rv);
        bus(0, 5'h04, 32'h0000_0000, 4'hf, rv);
        chk(rv, 32'h0000_0078);
        bus(0, 5'h18, 32'h0000_0000, 4'hf, rv);
        chk(rv, 32'h0000_0000);
        // every round changes the mode or the direction, so the design restarts unarmed like the model
        for (int r = 0; r < 24; r++) begin
            md = r % 8;
            dr = (r / 8) % 2;
            pl = int'($urandom_range(1000)) - 500;
            sl = int'($urandom_range(1000)) - 500;
            // wide band keeps the restart sample from arming either comparator
            hy = (pl > sl ? pl - sl : sl - pl) + int'($urandom_range(99));
            pu = 0;
            pd = 0;
            su = 0;
            sd = 0;
            wa = 0;
            dp = 0;
            ds = 0;
            sq = 0;
            tc = 0;
            qc = 0;
            bus(1, 5'h04, {16'h0000, 16'(pl)}, 4'hf, rv);
            bus(1, 5'h08, {16'h0000, 16'(sl)}, 4'hf, rv);
            bus(1, 5'h0c, 32'(hy), 4'hf, rv);
            bus(1, 5'h00, 32'(md) | (32'(dr) << 4), 4'hf, rv);
            bus(1, 5'h14, 32'h0000_0000, 4'hf, rv);
            step(sl, 1);
            repeat (200) step(int'($urandom_range(4000)) - 2000, $urandom_range(7) != 0);
            step(0, 0);
            bus(0, 5'h14, 32'h0000_0000, 4'hf, rv);
            chk(rv, {16'(qc), 16'(tc)});
            bus(0, 5'h10, 32'h0000_0000, 4'hf, rv);
            chk(rv, {28'h000_0000, 1'(sq), 1'(ds), 1'(dp), 1'(wa)});
        end
        stop_test();
    end
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule // tb_top
